// File: design/mad_consts.svh
/*
  Address map constants for the memory address decoder: window bounds in
  16-bit word addresses, vector table locations and timing counts.
  Assumes inclusion by bare name from the decoder module.
*/
`ifndef MAD_CONSTS_SVH
`define MAD_CONSTS_SVH

// ----------------------------------------------------------------------
// Program space
// ----------------------------------------------------------------------
`define MAD_P_FLASH_LO_16K 21'h000000
`define MAD_P_FLASH_LO_12K 21'h000800
`define MAD_P_FLASH_HI 21'h001fff
`define MAD_P_RAM_LO 21'h008000
`define MAD_P_RAM_HI 21'h0083ff
`define MAD_VEC_BOOT_16K 21'h000000
`define MAD_VEC_WDOG_16K 21'h000002
`define MAD_VEC_LAST_16K 21'h000065
`define MAD_VEC_BOOT_12K 21'h000800
`define MAD_VEC_WDOG_12K 21'h000802
`define MAD_VEC_LAST_12K 21'h000865

// ----------------------------------------------------------------------
// Data space
// ----------------------------------------------------------------------
`define MAD_X_RAM_HI 24'h0003ff
`define MAD_X_PERIPH_LO 24'h00f000
`define MAD_X_PERIPH_HI 24'h00ffff
`define MAD_X_DEBUG_LO 24'hffff00
`define MAD_X_SHORT_HI 24'h00003f

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define MAD_PSPACE_WAIT 2'h2

`endif

// File: design/mad_pkg.sv
/*
  Types shared by the memory address decoder modules.
  Assumes the constants header is available on the include path.
*/
package mad_pkg;

  typedef enum logic [4:0] {
    MAD_TGT_NONE = 5'h01,
    MAD_TGT_FLASH = 5'h02,
    MAD_TGT_RAM = 5'h04,
    MAD_TGT_PERIPH = 5'h08,
    MAD_TGT_DEBUG = 5'h10
  } mad_tgt_t;

  typedef enum logic [1:0] {
    MAD_SZ_BYTE = 2'h0,
    MAD_SZ_WORD = 2'h1,
    MAD_SZ_LONG = 2'h2
  } mad_size_t;

  typedef enum logic [1:0] {
    MAD_ST_IDLE = 2'h1,
    MAD_ST_WAIT = 2'h2
  } mad_state_t;

endpackage

// File: design/mad_ram.sv
/*
  Unified word RAM with one read-write port and one read-only port.
  Assumes a single clock; a write and a read of the same word in one cycle
  returns the old contents on both ports.
*/
`timescale 1ns/1ps
module mad_ram #(
  parameter int AW = 10
) (
  input wire logic clk,
  input wire logic a_we,
  input wire logic [AW-1:0] a_addr,
  input wire logic [15:0] a_wdata,
  output logic [15:0] a_rdata,
  input wire logic [AW-1:0] b_addr,
  output logic [15:0] b_rdata
);

  logic [15:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
  end

  assign a_rdata = mem[a_addr];
  assign b_rdata = mem[b_addr];

endmodule // mad_ram

// File: design/mad_decoder.sv
/*
  Memory address decoder: steers the program fetch bus, the primary data bus
  and the secondary read bus onto program flash, unified RAM, the peripheral
  window and the debug window.
  Assumes flash, peripheral and debug targets answer combinationally in the
  cycle they are selected, and masters hold a request until it is answered.
*/
`timescale 1ns/1ps
`include "mad_consts.svh"
// Overview of operation
// - Flash in program space only; RAM both.
// - All addresses count 16-bit words.
// - 16K part: flash at 0x0000-0x1FFF.
// - 16K part: vectors from 0x0000, watchdog 0x0002.
// - 12K part: flash and vectors from 0x0800.
// - Program 0x8000-0x83FF aliases data RAM.
// - Data 0x0000-0x03FF is unified RAM.
// - Peripherals at 0xF000, debug at 0xFFFF00.
// - Fetch uses program address, returns fetch bus.
// - Program-space data accesses take extra cycles.
// - Byte, word, long accepted; only 16 bits move per access.
// - Secondary read runs alongside primary access.
// - Short form reaches first 64 data words.
// - Flash written only via flash interface.
module mad_decoder #(
  parameter bit SMALL_FLASH = 1'b0,
  parameter int RAM_AW = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic fetch_req,
  input wire logic [20:0] prog_addr_bus,
  output logic [15:0] prog_fetch_bus,
  output logic fetch_ack,
  input wire logic d_req,
  input wire logic d_write,
  input wire logic d_pspace,
  input wire logic d_short,
  input wire logic [5:0] d_short_addr,
  input wire mad_pkg::mad_size_t d_size,
  input wire logic [23:0] primary_data_addr_bus,
  input wire logic [31:0] primary_write_bus,
  output logic [31:0] primary_read_bus,
  output logic d_ack,
  input wire logic [23:0] secondary_data_addr_bus,
  output logic [15:0] secondary_read_bus,
  output logic [20:0] boot_vector,
  output logic [20:0] watchdog_reset_vector,
  output logic vec_hit,
  input wire logic [15:0] flash_rdata,
  output logic [20:0] flash_addr,
  input wire logic [15:0] periph_rdata,
  input wire logic [15:0] debug_rdata,
  output logic periph_sel,
  output logic debug_sel,
  output logic [15:0] tgt_addr,
  output logic tgt_we,
  output logic [15:0] tgt_wdata
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic mad_pkg::mad_tgt_t dec_p(input logic [20:0] a);
    logic [20:0] lo;
    lo = SMALL_FLASH ? `MAD_P_FLASH_LO_12K : `MAD_P_FLASH_LO_16K;
    if (a >= lo && a <= `MAD_P_FLASH_HI) begin
      dec_p = mad_pkg::MAD_TGT_FLASH;
    end else if (a >= `MAD_P_RAM_LO && a <= `MAD_P_RAM_HI) begin
      dec_p = mad_pkg::MAD_TGT_RAM;
    end else begin
      dec_p = mad_pkg::MAD_TGT_NONE;
    end
  endfunction

  function automatic mad_pkg::mad_tgt_t dec_x(input logic [23:0] a);
    if (a <= `MAD_X_RAM_HI) begin
      dec_x = mad_pkg::MAD_TGT_RAM;
    end else if (a >= `MAD_X_PERIPH_LO && a <= `MAD_X_PERIPH_HI) begin
      dec_x = mad_pkg::MAD_TGT_PERIPH;
    end else if (a >= `MAD_X_DEBUG_LO) begin
      dec_x = mad_pkg::MAD_TGT_DEBUG;
    end else begin
      dec_x = mad_pkg::MAD_TGT_NONE;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Primary data path
  // ----------------------------------------------------------------------
  // Addresses are word indices throughout, so no byte shift is applied.
  logic [23:0] d_addr;
  logic [20:0] d_paddr;
  mad_pkg::mad_tgt_t d_tgt;
  logic [20:0] f_paddr;
  mad_pkg::mad_tgt_t f_tgt;
  mad_pkg::mad_state_t st_r, st_nxt;
  logic [RAM_AW-1:0] ram_a_addr;
  logic [RAM_AW-1:0] ram_b_addr;
  logic [15:0] ram_a_rdata;
  logic [15:0] ram_b_rdata;
  logic ram_we;
  logic [15:0] d_rword;

  assign d_addr = d_short ? {18'h00000, d_short_addr} : primary_data_addr_bus;
  assign d_paddr = d_addr[20:0];
  assign f_paddr = prog_addr_bus;
  assign f_tgt = dec_p(f_paddr);

  always_comb begin
    if (d_pspace) begin
      d_tgt = dec_p(d_paddr);
    end else begin
      d_tgt = dec_x(d_addr);
    end
  end

  // Data port owns the RAM write port; fetch wins only when no data access.
  assign ram_a_addr = d_req ? d_addr[RAM_AW-1:0] : f_paddr[RAM_AW-1:0];
  // Ordinary stores to flash never reach it: only RAM and windows are written.
  assign ram_we = d_req && d_write && d_tgt == mad_pkg::MAD_TGT_RAM && st_r == mad_pkg::MAD_ST_IDLE;
  assign ram_b_addr = secondary_data_addr_bus[RAM_AW-1:0];

  mad_ram #(
    .AW(RAM_AW)
  ) u_ram (
    .clk(clk),
    .a_we(ram_we),
    .a_addr(ram_a_addr),
    .a_wdata(primary_write_bus[15:0]),
    .a_rdata(ram_a_rdata),
    .b_addr(ram_b_addr),
    .b_rdata(ram_b_rdata)
  );

  always_comb begin
    unique case (d_tgt)
      mad_pkg::MAD_TGT_FLASH: d_rword = flash_rdata;
      mad_pkg::MAD_TGT_RAM: d_rword = ram_a_rdata;
      mad_pkg::MAD_TGT_PERIPH: d_rword = periph_rdata;
      mad_pkg::MAD_TGT_DEBUG: d_rword = debug_rdata;
      default: d_rword = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------------
  // Sequencing and registered outputs
  // ----------------------------------------------------------------------
  // Program-space data accesses borrow the fetch path, hence the extra wait.
  logic [1:0] wait_r, wait_nxt;
  logic [31:0] prd_r, prd_nxt;
  logic d_ack_r, d_ack_nxt;
  logic [15:0] pfb_r, pfb_nxt;
  logic f_ack_r, f_ack_nxt;
  logic [15:0] srb_r, srb_nxt;
  logic psel_r, psel_nxt, dsel_r, dsel_nxt, twe_r, twe_nxt;
  logic [15:0] taddr_r, taddr_nxt, twd_r, twd_nxt;
  logic [20:0] faddr_r, faddr_nxt;
  logic vec_r, vec_nxt;
  logic [31:0] rd_ext;

  always_comb begin
    unique case (d_size)
      mad_pkg::MAD_SZ_BYTE: rd_ext = {24'h000000, d_rword[7:0]};
      mad_pkg::MAD_SZ_WORD: rd_ext = {16'h0000, d_rword};
      default: rd_ext = {16'h0000, d_rword};
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    wait_nxt = wait_r;
    prd_nxt = prd_r;
    d_ack_nxt = 1'b0;
    unique case (st_r)
      mad_pkg::MAD_ST_IDLE: begin
        if (d_req && !d_ack_r) begin
          if (d_pspace) begin
            st_nxt = mad_pkg::MAD_ST_WAIT;
            wait_nxt = `MAD_PSPACE_WAIT;
          end else begin
            d_ack_nxt = 1'b1;
            prd_nxt = d_write ? 32'h00000000 : rd_ext;
          end
        end
      end
      mad_pkg::MAD_ST_WAIT: begin
        wait_nxt = wait_r - 2'h1;
        if (wait_r == 2'h1) begin
          st_nxt = mad_pkg::MAD_ST_IDLE;
          d_ack_nxt = 1'b1;
          prd_nxt = d_write ? 32'h00000000 : rd_ext;
        end
      end
      default: st_nxt = mad_pkg::MAD_ST_IDLE;
    endcase
    f_ack_nxt = fetch_req && !d_req && !f_ack_r;
    unique case (f_tgt)
      mad_pkg::MAD_TGT_FLASH: pfb_nxt = flash_rdata;
      mad_pkg::MAD_TGT_RAM: pfb_nxt = ram_a_rdata;
      default: pfb_nxt = 16'h0000;
    endcase
    if (!f_ack_nxt) begin
      pfb_nxt = pfb_r;
    end
    srb_nxt = dec_x(secondary_data_addr_bus) == mad_pkg::MAD_TGT_RAM ? ram_b_rdata : 16'h0000;
    psel_nxt = d_req && d_tgt == mad_pkg::MAD_TGT_PERIPH && !d_pspace;
    dsel_nxt = d_req && d_tgt == mad_pkg::MAD_TGT_DEBUG && !d_pspace;
    twe_nxt = d_write && (psel_nxt || dsel_nxt);
    taddr_nxt = d_addr[15:0];
    twd_nxt = primary_write_bus[15:0];
    faddr_nxt = d_req ? d_paddr : f_paddr;
    vec_nxt = SMALL_FLASH ? (f_paddr >= `MAD_VEC_BOOT_12K && f_paddr <= `MAD_VEC_LAST_12K)
                          : (f_paddr <= `MAD_VEC_LAST_16K);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= mad_pkg::MAD_ST_IDLE;
      wait_r <= 2'h0;
      prd_r <= 32'h00000000;
      d_ack_r <= 1'b0;
      pfb_r <= 16'h0000;
      f_ack_r <= 1'b0;
      srb_r <= 16'h0000;
      psel_r <= 1'b0;
      dsel_r <= 1'b0;
      twe_r <= 1'b0;
      taddr_r <= 16'h0000;
      twd_r <= 16'h0000;
      faddr_r <= 21'h000000;
      vec_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      wait_r <= wait_nxt;
      prd_r <= prd_nxt;
      d_ack_r <= d_ack_nxt;
      pfb_r <= pfb_nxt;
      f_ack_r <= f_ack_nxt;
      srb_r <= srb_nxt;
      psel_r <= psel_nxt;
      dsel_r <= dsel_nxt;
      twe_r <= twe_nxt;
      taddr_r <= taddr_nxt;
      twd_r <= twd_nxt;
      faddr_r <= faddr_nxt;
      vec_r <= vec_nxt;
    end
  end

  // Vector locations are fixed by variant; only the 16K map starts at zero.
  logic [20:0] boot_r, wdog_r;
  always_ff @(posedge clk) begin
    boot_r <= SMALL_FLASH ? `MAD_VEC_BOOT_12K : `MAD_VEC_BOOT_16K;
    wdog_r <= SMALL_FLASH ? `MAD_VEC_WDOG_12K : `MAD_VEC_WDOG_16K;
  end

  assign primary_read_bus = prd_r;
  assign d_ack = d_ack_r;
  assign prog_fetch_bus = pfb_r;
  assign fetch_ack = f_ack_r;
  assign secondary_read_bus = srb_r;
  assign periph_sel = psel_r;
  assign debug_sel = dsel_r;
  assign tgt_we = twe_r;
  assign tgt_addr = taddr_r;
  assign tgt_wdata = twd_r;
  assign flash_addr = faddr_r;
  assign vec_hit = vec_r;
  assign boot_vector = boot_r;
  assign watchdog_reset_vector = wdog_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_pspace_slow;
    @(posedge clk) disable iff (rst)
      (st_r == mad_pkg::MAD_ST_IDLE && d_req && d_pspace && !d_ack_r)
      |=> !d_ack ##1 !d_ack ##1 d_ack;
  endproperty
  a_pspace_slow: assert property (p_pspace_slow) else $error("pspace ack timing");

  property p_xspace_fast;
    @(posedge clk) disable iff (rst)
      (st_r == mad_pkg::MAD_ST_IDLE && d_req && !d_pspace && !d_ack_r) |=> d_ack;
  endproperty
  a_xspace_fast: assert property (p_xspace_fast) else $error("data ack late");

  property p_no_flash_store;
    @(posedge clk) disable iff (rst) (d_req && d_write && d_tgt == mad_pkg::MAD_TGT_FLASH) |-> !ram_we;
  endproperty
  a_no_flash_store: assert property (p_no_flash_store) else $error("store hit flash");

  property p_reserved_zero;
    @(posedge clk) disable iff (rst)
      (d_req && !d_write && !d_pspace && !d_ack_r && st_r == mad_pkg::MAD_ST_IDLE
       && d_tgt == mad_pkg::MAD_TGT_NONE) |=> primary_read_bus == 32'h00000000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved read nonzero");

  property p_periph_sel;
    @(posedge clk) disable iff (rst)
      (d_req && !d_pspace && primary_data_addr_bus[23:12] == 12'h00f && !d_short) |=> periph_sel;
  endproperty
  a_periph_sel: assert property (p_periph_sel) else $error("periph not selected");

  property p_debug_sel;
    @(posedge clk) disable iff (rst)
      (d_req && !d_pspace && primary_data_addr_bus[23:8] == 16'hffff && !d_short) |=> debug_sel;
  endproperty
  a_debug_sel: assert property (p_debug_sel) else $error("debug not selected");

  property p_sec_ram;
    @(posedge clk) disable iff (rst)
      (secondary_data_addr_bus[23:10] == 14'h0000) |=> secondary_read_bus == $past(ram_b_rdata);
  endproperty
  a_sec_ram: assert property (p_sec_ram) else $error("secondary read wrong");

  property p_fetch_reserved;
    @(posedge clk) disable iff (rst)
      (fetch_req && !d_req && !f_ack_r && f_tgt == mad_pkg::MAD_TGT_NONE)
      |=> fetch_ack && prog_fetch_bus == 16'h0000;
  endproperty
  a_fetch_reserved: assert property (p_fetch_reserved) else $error("reserved fetch nonzero");

endmodule // mad_decoder

// File: test/mad_tgt_model.sv
/*
  Target model for the decoder: program flash, peripheral and debug read words.
  Assumes the decoder samples these words combinationally from the live address.
*/
`timescale 1ns/1ps
module mad_tgt_model (
  input wire logic d_req,
  input wire logic [20:0] prog_addr_bus,
  input wire logic [23:0] primary_data_addr_bus,
  output logic [15:0] flash_rdata,
  output logic [15:0] periph_rdata,
  output logic [15:0] debug_rdata
);
  // ----------------------------------------------------------------------
  // Read words
  // ----------------------------------------------------------------------
  // Each target mixes its own pattern into the word address, so a wrong steer shows.
  logic [15:0] cur_word;
  assign cur_word = d_req ? primary_data_addr_bus[15:0] : prog_addr_bus[15:0];
  assign flash_rdata = 16'ha500 ^ cur_word;
  assign periph_rdata = 16'h3c00 ^ primary_data_addr_bus[15:0];
  assign debug_rdata = 16'hc300 ^ primary_data_addr_bus[15:0];
endmodule // mad_tgt_model

// File: test/tb_top.sv
/*
  Self-checking bench for the memory address decoder, 16 KB and 12 KB flash variants.
  Assumes the target model file is compiled before it.
*/
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------------
  logic clk, rst, fetch_req, d_req, d_write, d_pspace, d_short, fetch_ack, d_ack, vec_hit;
  logic periph_sel, debug_sel, tgt_we;
  logic [5:0] d_short_addr;
  mad_pkg::mad_size_t d_size;
  logic [20:0] prog_addr_bus, boot_vector, watchdog_reset_vector, flash_addr;
  logic [23:0] primary_data_addr_bus, secondary_data_addr_bus;
  logic [31:0] primary_write_bus, primary_read_bus;
  logic [15:0] prog_fetch_bus, secondary_read_bus, flash_rdata, periph_rdata, debug_rdata;
  logic [15:0] tgt_addr, tgt_wdata, w;
  logic [31:0] r;
  logic [2:0] sel;
  logic [15:0] ta, twd, s_pfb;
  logic [20:0] s_boot, s_wdog;
  logic s_vec;
  int n, n_mismatch, cmp_count, cyc;

  mad_decoder #(.SMALL_FLASH(1'b0), .RAM_AW(10)) dut (.clk(clk), .rst(rst),
    .fetch_req(fetch_req), .prog_addr_bus(prog_addr_bus), .prog_fetch_bus(prog_fetch_bus),
    .fetch_ack(fetch_ack), .d_req(d_req), .d_write(d_write), .d_pspace(d_pspace),
    .d_short(d_short), .d_short_addr(d_short_addr), .d_size(d_size),
    .primary_data_addr_bus(primary_data_addr_bus), .primary_write_bus(primary_write_bus),
    .primary_read_bus(primary_read_bus), .d_ack(d_ack),
    .secondary_data_addr_bus(secondary_data_addr_bus),
    .secondary_read_bus(secondary_read_bus), .boot_vector(boot_vector),
    .watchdog_reset_vector(watchdog_reset_vector), .vec_hit(vec_hit),
    .flash_rdata(flash_rdata), .flash_addr(flash_addr), .periph_rdata(periph_rdata),
    .debug_rdata(debug_rdata), .periph_sel(periph_sel), .debug_sel(debug_sel),
    .tgt_addr(tgt_addr), .tgt_we(tgt_we), .tgt_wdata(tgt_wdata));

  // The small-flash variant shares every input, so both maps can be checked from one fetch.
  mad_decoder #(.SMALL_FLASH(1'b1), .RAM_AW(10)) dut_small (.clk(clk), .rst(rst),
    .fetch_req(fetch_req), .prog_addr_bus(prog_addr_bus), .prog_fetch_bus(s_pfb),
    .fetch_ack(), .d_req(d_req), .d_write(d_write), .d_pspace(d_pspace),
    .d_short(d_short), .d_short_addr(d_short_addr), .d_size(d_size),
    .primary_data_addr_bus(primary_data_addr_bus), .primary_write_bus(primary_write_bus),
    .primary_read_bus(), .d_ack(), .secondary_data_addr_bus(secondary_data_addr_bus),
    .secondary_read_bus(), .boot_vector(s_boot), .watchdog_reset_vector(s_wdog),
    .vec_hit(s_vec), .flash_rdata(flash_rdata), .flash_addr(), .periph_rdata(periph_rdata),
    .debug_rdata(debug_rdata), .periph_sel(), .debug_sel(), .tgt_addr(), .tgt_we(),
    .tgt_wdata());

  mad_tgt_model tgt (.d_req(d_req), .prog_addr_bus(prog_addr_bus),
    .primary_data_addr_bus(primary_data_addr_bus), .flash_rdata(flash_rdata),
    .periph_rdata(periph_rdata), .debug_rdata(debug_rdata));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Called just after a falling edge; the request is held until its ack is seen.
  task automatic fetch(input logic [20:0] a);
    prog_addr_bus = a;
    fetch_req = 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (fetch_ack !== 1'b1 && n < 20);
    w = prog_fetch_bus;
    if (fetch_ack !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t: fetch not answered", $time);
    end
    @(negedge clk);
    fetch_req = 1'b0;
    // An idle cycle keeps the next request out of the release time step.
    @(negedge clk);
  endtask

  task automatic dop(input logic ps, input logic wr, input logic sh, input logic [5:0] sa,
      input mad_pkg::mad_size_t sz, input logic [23:0] a, input logic [31:0] wd);
    d_pspace = ps;
    d_write = wr;
    d_short = sh;
    d_short_addr = sa;
    d_size = sz;
    primary_data_addr_bus = a;
    primary_write_bus = wd;
    d_req = 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (d_ack !== 1'b1 && n < 20);
    r = primary_read_bus;
    // Target strobes stand only in the ack cycle, so they are taken here.
    sel = {periph_sel, debug_sel, tgt_we};
    ta = tgt_addr;
    twd = tgt_wdata;
    if (d_ack !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t: data access not answered", $time);
    end
    @(negedge clk);
    d_req = 1'b0;
    @(negedge clk);
  endtask

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_fetch;
    fetch(21'h000000);
    chk(w, 16'ha500);
    chk(n, 1);
    fetch(21'h001fff);
    chk(w, 16'hbaff);
    chk(flash_addr, 21'h001fff);
    fetch(21'h002000);
    chk(w, 16'h0000);
    fetch(21'h007fff);
    chk(w, 16'h0000);
    fetch(21'h008800);
    chk(w, 16'h0000);
    $display("test fetch done");
  endtask

  task automatic t_vec;
    chk(boot_vector, 21'h000000);
    chk(watchdog_reset_vector, 21'h000002);
    chk(s_boot, 21'h000800);
    chk(s_wdog, 21'h000802);
    fetch(21'h000065);
    chk(vec_hit, 1'b1);
    chk(s_vec, 1'b0);
    fetch(21'h000066);
    chk(vec_hit, 1'b0);
    fetch(21'h0007ff);
    chk(w, 16'ha2ff);
    chk(s_pfb, 16'h0000);
    fetch(21'h000865);
    chk(s_pfb, 16'had65);
    chk(s_vec, 1'b1);
    chk(vec_hit, 1'b0);
    $display("test vectors done");
  endtask

  // The secondary port reads the same word while the primary bus is busy.
  task automatic t_ram;
    dop(1'b0, 1'b1, 1'b0, 6'h00, mad_pkg::MAD_SZ_WORD, 24'h000005, 32'h00001234);
    chk(n, 1);
    secondary_data_addr_bus = 24'h000005;
    dop(1'b0, 1'b0, 1'b0, 6'h00, mad_pkg::MAD_SZ_WORD, 24'h000005, 32'h0);
    chk(r, 32'h00001234);
    chk(secondary_read_bus, 16'h1234);
    dop(1'b0, 1'b0, 1'b0, 6'h00, mad_pkg::MAD_SZ_LONG, 24'h000005, 32'h0);
    chk(r, 32'h00001234);
    dop(1'b0, 1'b0, 1'b0, 6'h00, mad_pkg::MAD_SZ_BYTE, 24'h000005, 32'h0);
    chk(r, 32'h00000034);
    dop(1'b0, 1'b0, 1'b1, 6'h05, mad_pkg::MAD_SZ_WORD, 24'h000300, 32'h0);
    chk(r, 32'h00001234);
    fetch(21'h008005);
    chk(w, 16'h1234);
    // The top RAM word written through program space lands on its data alias.
    dop(1'b1, 1'b1, 1'b0, 6'h00, mad_pkg::MAD_SZ_WORD, 24'h0083ff, 32'h00005a5a);
    chk(n, 3);
    dop(1'b0, 1'b0, 1'b0, 6'h00, mad_pkg::MAD_SZ_WORD, 24'h0003ff, 32'h0);
    chk(r, 32'h00005a5a);
    fetch(21'h0083ff);
    chk(w, 16'h5a5a);
    dop(1'b0, 1'b1, 1'b0, 6'h00, mad_pkg::MAD_SZ_WORD, 24'h000010, 32'h00000777);
    dop(1'b0, 1'b0, 1'b0, 6'h00, mad_pkg::MAD_SZ_WORD, 24'h000010, 32'h0);
    chk(r, 32'h00000777);
    $display("test ram done");
  endtask

  task automatic t_pspace;
    dop(1'b1, 1'b0, 1'b0, 6'h00, mad_pkg::MAD_SZ_WORD, 24'h000010, 32'h0);
    chk(r, 32'h0000a510);
    chk(n, 3);
    dop(1'b1, 1'b0, 1'b0, 6'h00, mad_pkg::MAD_SZ_WORD, 24'h008005, 32'h0);
    chk(r, 32'h00001234);
    dop(1'b1, 1'b0, 1'b0, 6'h00, mad_pkg::MAD_SZ_WORD, 24'h002000, 32'h0);
    chk(r, 32'h0);
    // A store to flash must not fold onto RAM through the low address bits.
    dop(1'b1, 1'b1, 1'b0, 6'h00, mad_pkg::MAD_SZ_WORD, 24'h000005, 32'h0000dead);
    dop(1'b0, 1'b0, 1'b0, 6'h00, mad_pkg::MAD_SZ_WORD, 24'h000005, 32'h0);
    chk(r, 32'h00001234);
    $display("test program space done");
  endtask

  task automatic t_win;
    dop(1'b0, 1'b0, 1'b0, 6'h00, mad_pkg::MAD_SZ_WORD, 24'h00f000, 32'h0);
    chk(r, 32'h0000cc00);
    chk(sel, 3'h4);
    chk(ta, 16'hf000);
    dop(1'b0, 1'b1, 1'b0, 6'h00, mad_pkg::MAD_SZ_WORD, 24'h00f012, 32'h0000beef);
    chk(sel, 3'h5);
    chk(ta, 16'hf012);
    chk(twd, 16'hbeef);
    dop(1'b0, 1'b0, 1'b0, 6'h00, mad_pkg::MAD_SZ_WORD, 24'hffff00, 32'h0);
    chk(r, 32'h00003c00);
    chk(sel, 3'h2);
    dop(1'b0, 1'b0, 1'b0, 6'h00, mad_pkg::MAD_SZ_WORD, 24'hfffeff, 32'h0);
    chk(r, 32'h0);
    chk(sel, 3'h0);
    dop(1'b0, 1'b0, 1'b0, 6'h00, mad_pkg::MAD_SZ_WORD, 24'h010000, 32'h0);
    chk(r, 32'h0);
    // A reserved store must not fold onto RAM through the low address bits.
    dop(1'b0, 1'b1, 1'b0, 6'h00, mad_pkg::MAD_SZ_WORD, 24'h000405, 32'h0000dead);
    chk(sel, 3'h0);
    dop(1'b0, 1'b0, 1'b0, 6'h00, mad_pkg::MAD_SZ_WORD, 24'h000405, 32'h0);
    chk(r, 32'h0);
    dop(1'b0, 1'b0, 1'b0, 6'h00, mad_pkg::MAD_SZ_WORD, 24'h000005, 32'h0);
    chk(r, 32'h00001234);
    $display("test windows done");
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      close_out;
    end
  end

  initial begin
    rst = 1'b1;
    {fetch_req, d_req, d_write, d_pspace, d_short} = 5'h00;
    d_short_addr = 6'h00;
    d_size = mad_pkg::MAD_SZ_WORD;
    prog_addr_bus = 21'h000000;
    primary_data_addr_bus = 24'h000000;
    // The secondary port starts outside RAM, so no unwritten word is read.
    secondary_data_addr_bus = 24'h000400;
    primary_write_bus = 32'h00000000;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_fetch;
    t_vec;
    t_ram;
    t_pspace;
    t_win;
    close_out;
  end
endmodule // tb_top
